//--- src/cei_consts.svh
// offsets, bit positions, field masks and reset values of the event interrupt unit
// assumes inclusion by bare name from the design module and the bench modules
`ifndef CEI_CONSTS_SVH
`define CEI_CONSTS_SVH

// register offsets, 16-bit word addresses
`define CEI_ADDR_GPIO_EVT 16'h0730
`define CEI_ADDR_CORE_EVT 16'h0731
`define CEI_ADDR_RAW 16'h0732
`define CEI_ADDR_GPIO_MASK 16'h0738
`define CEI_ADDR_CORE_MASK 16'h0739
`define CEI_ADDR_CTRL 16'h0740

// core event and level bit positions, and the control global mask bit
`define CEI_BIT_SERVO_B 12
`define CEI_BIT_SERVO_A 11
`define CEI_BIT_SEQ 10
`define CEI_BIT_BUFERR 9
`define CEI_BIT_PATH2 7
`define CEI_BIT_PATH1 6
`define CEI_BIT_CLKSW 3
`define CEI_BIT_LOCK 2
`define CEI_BIT_HP 1
`define CEI_BIT_MIC 0
`define CEI_BIT_GLOBAL_MASK 0

// implemented bits of each register
`define CEI_GPIO_VALID 16'h000f
`define CEI_CORE_VALID 16'h1ecf
`define CEI_RAW_VALID 16'h1ec4
`define CEI_CTRL_VALID 16'h0001

// sources that latch on both edges
`define CEI_GPIO_BOTH 16'h000f
`define CEI_CORE_BOTH 16'h0004

// reset values
`define CEI_EVT_RESET 16'h0000
`define CEI_GPIO_MASK_RESET 16'h000f
`define CEI_CORE_MASK_RESET 16'h1ecf
`define CEI_CTRL_RESET 16'h0001

`endif

//--- src/cei_pkg.sv
// types shared by the event interrupt unit
// assumes the constants header sits beside it
package cei_pkg;

    typedef logic [15:0] cei_word_t;

    // one register access from software
    typedef struct packed {
        logic [15:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } cei_bus_s;

    // on-chip event sources, all on mclk
    typedef struct packed {
        logic servo_pair_b_level;
        logic servo_pair_a_level;
        logic sequencer_idle_level;
        logic buffer_error_level;
        logic path2_activity_level;
        logic path1_activity_level;
        logic clock_switch_done;
        logic loop_lock_level;
        logic headphone_detect_done;
        logic mic_detect;
    } cei_src_s;

endpackage

//--- src/cei_sync.sv
// two-stage level synchroniser for pin inputs
// assumes asynchronous inputs and a common clock enable
`timescale 1ns/1ps
module cei_sync
    import cei_pkg::*;
#(
    parameter int W = 4
)
(
    // clock and reset
    input wire logic mclk,
    input wire logic reset,
    input wire logic clk_en,
    // levels
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);

    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;

    // first stage feeds the second stage only
    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            meta_q <= '0;
            sync_q <= '0;
        end
        else if (clk_en)
        begin
            meta_q <= async_in;
            sync_q <= meta_q;
        end
    end

    assign sync_out = sync_q;

endmodule

//--- src/cei_edge.sv
// edge detector producing one-cycle set pulses
// assumes inputs already on mclk; both_sel picks both-edge bits
`timescale 1ns/1ps
module cei_edge
    import cei_pkg::*;
#(
    parameter int W = 16
)
(
    // clock and reset
    input wire logic mclk,
    input wire logic reset,
    input wire logic clk_en,
    // levels and pulses
    input wire logic [W-1:0] level,
    input wire logic [W-1:0] both_sel,
    output logic [W-1:0] pulse
);

    logic [W-1:0] prev_q;
    logic primed_q;

    // first enabled cycle only loads history, so levels high at reset give no event
    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            prev_q <= '0;
            primed_q <= 1'b0;
        end
        else if (clk_en)
        begin
            prev_q <= level;
            primed_q <= 1'b1;
        end
    end

    assign pulse = (primed_q && clk_en)
        ? ((level & ~prev_q) | (both_sel & ~level & prev_q)) : '0;

endmodule

//--- src/cei_top.sv
// event interrupt unit: edge latches, masks, raw levels and interrupt output
// assumes gpio pins are asynchronous; all other sources run on mclk
//
// Contract
// - gpio one to four and loop lock latch on rising and falling edges
// - event bits stay set until software writes one; zero writes ignored
// - servo pair b rising latches core bit 12, pair a bit 11
// - sequencer done rising edge latches core bit 10 only
// - buffer error rising edge latches core bit 9
// - activity detect rising edges latch path2 bit 7, path1 bit 6
// - clock switch done rising edge latches core bit 3
// - headphone detect done rising edge latches core bit 1
// - mic detect rising edge latches core bit 0
// - raw bits 12 and 11 show live servo completion levels
// - raw bit 10 reads zero while sequencing, one when idle
// - raw bit 9 reads one while buffer error exists
// - raw bits 7 and 6 show live path activity levels
// - raw bit 2 shows live loop lock level
// - each source has mask bit at same position; one masks it
// - all per-source mask bits reset to one
// - control bit 0, reset one, suppresses interrupt output while set
// - interrupt is or of latched event bits with mask zero
// - masked sources still latch and read back
// - interrupt holds until every unmasked latched bit is cleared
//
// The plain strobed port was left to the implementer.
`timescale 1ns/1ps
`include "cei_consts.svh"
module cei_top
    import cei_pkg::*;
(
    // clock, reset, enable
    input wire logic mclk,
    input wire logic reset,
    input wire logic clk_en,
    // register port
    input wire cei_bus_s bus,
    output cei_word_t rdata,
    // gpio pins, asynchronous
    input wire logic [3:0] gpio_pin,
    // on-chip sources
    input wire cei_src_s src,
    // interrupt to host
    output logic irq
);

    // register state
    cei_word_t gpio_evt_q;
    cei_word_t gpio_evt_d;
    cei_word_t core_evt_q;
    cei_word_t core_evt_d;
    cei_word_t gpio_mask_q;
    cei_word_t core_mask_q;
    cei_word_t ctrl_q;
    cei_word_t rdata_q;
    cei_word_t rdata_d;
    logic irq_q;
    logic irq_d;

    // source handling
    logic [3:0] gpio_sync;
    logic [3:0] gpio_pulse;
    cei_word_t core_level;
    cei_word_t core_pulse;
    cei_word_t raw_level;
    logic [1:0] gpio_fill_q;
    logic gpio_edge_en;

    // decoded strobes
    logic wr_gpio_evt;
    logic wr_core_evt;
    logic wr_gpio_mask;
    logic wr_core_mask;
    logic wr_ctrl;

    // true when a strobe targets the given offset
    function automatic logic hit(input cei_word_t addr, input cei_word_t offs, input logic strobe);
        hit = strobe && (addr == offs);
    endfunction

    // sticky latch update: set wins over a same-cycle clear
    function automatic cei_word_t w1c_next(
        input cei_word_t cur,
        input cei_word_t set,
        input logic clr_en,
        input cei_word_t clr,
        input cei_word_t valid
    );
        cei_word_t keep;
        keep = clr_en ? (cur & ~clr) : cur;
        w1c_next = (keep | set) & valid;
    endfunction

    // places the core sources at their event bit positions
    function automatic cei_word_t pack_core(input cei_src_s s);
        cei_word_t w;
        w = '0;
        w[`CEI_BIT_SERVO_B] = s.servo_pair_b_level;
        w[`CEI_BIT_SERVO_A] = s.servo_pair_a_level;
        w[`CEI_BIT_SEQ] = s.sequencer_idle_level;
        w[`CEI_BIT_BUFERR] = s.buffer_error_level;
        w[`CEI_BIT_PATH2] = s.path2_activity_level;
        w[`CEI_BIT_PATH1] = s.path1_activity_level;
        w[`CEI_BIT_CLKSW] = s.clock_switch_done;
        w[`CEI_BIT_LOCK] = s.loop_lock_level;
        w[`CEI_BIT_HP] = s.headphone_detect_done;
        w[`CEI_BIT_MIC] = s.mic_detect;
        pack_core = w;
    endfunction

    // pins are asynchronous, so two stages before any edge logic
    cei_sync #(
        .W(4)
    ) u_gpio_sync (
        .mclk(mclk),
        .reset(reset),
        .clk_en(clk_en),
        .async_in(gpio_pin),
        .sync_out(gpio_sync)
    );

    // gpio history waits until both sync stages hold real pin samples,
    // otherwise a pin held high through reset would read as a rising edge
    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            gpio_fill_q <= 2'b00;
        end
        else if (clk_en)
        begin
            gpio_fill_q <= {gpio_fill_q[0], 1'b1};
        end
    end

    assign gpio_edge_en = clk_en && gpio_fill_q[1];

    cei_edge #(
        .W(4)
    ) u_gpio_edge (
        .mclk(mclk),
        .reset(reset),
        .clk_en(gpio_edge_en),
        .level(gpio_sync),
        .both_sel(4'(`CEI_GPIO_BOTH)),
        .pulse(gpio_pulse)
    );

    assign core_level = pack_core(src);

    cei_edge #(
        .W(16)
    ) u_core_edge (
        .mclk(mclk),
        .reset(reset),
        .clk_en(clk_en),
        .level(core_level),
        .both_sel(`CEI_CORE_BOTH),
        .pulse(core_pulse)
    );

    assign raw_level = core_level & `CEI_RAW_VALID;

    // write decode
    assign wr_gpio_evt = hit(bus.addr, `CEI_ADDR_GPIO_EVT, bus.wr);
    assign wr_core_evt = hit(bus.addr, `CEI_ADDR_CORE_EVT, bus.wr);
    assign wr_gpio_mask = hit(bus.addr, `CEI_ADDR_GPIO_MASK, bus.wr);
    assign wr_core_mask = hit(bus.addr, `CEI_ADDR_CORE_MASK, bus.wr);
    assign wr_ctrl = hit(bus.addr, `CEI_ADDR_CTRL, bus.wr);

    always_comb
    begin
        gpio_evt_d = w1c_next(gpio_evt_q, {12'h000, gpio_pulse}, wr_gpio_evt,
            bus.wdata, `CEI_GPIO_VALID);
        core_evt_d = w1c_next(core_evt_q, core_pulse, wr_core_evt,
            bus.wdata, `CEI_CORE_VALID);
    end

    // gpio event latches
    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            gpio_evt_q <= `CEI_EVT_RESET;
        end
        else if (clk_en)
        begin
            gpio_evt_q <= gpio_evt_d;
        end
    end

    // core event latches
    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            core_evt_q <= `CEI_EVT_RESET;
        end
        else if (clk_en)
        begin
            core_evt_q <= core_evt_d;
        end
    end

    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            gpio_mask_q <= `CEI_GPIO_MASK_RESET;
        end
        else if (clk_en && wr_gpio_mask)
        begin
            gpio_mask_q <= bus.wdata & `CEI_GPIO_VALID;
        end
    end

    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            core_mask_q <= `CEI_CORE_MASK_RESET;
        end
        else if (clk_en && wr_core_mask)
        begin
            core_mask_q <= bus.wdata & `CEI_CORE_VALID;
        end
    end

    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            ctrl_q <= `CEI_CTRL_RESET;
        end
        else if (clk_en && wr_ctrl)
        begin
            ctrl_q <= bus.wdata & `CEI_CTRL_VALID;
        end
    end

    // read mux; unmapped offsets return zero and reads have no side effects
    always_comb
    begin
        rdata_d = '0;
        if (bus.rd)
        begin
            case (bus.addr)
                `CEI_ADDR_GPIO_EVT:
                begin
                    rdata_d = gpio_evt_q;
                end
                `CEI_ADDR_CORE_EVT:
                begin
                    rdata_d = core_evt_q;
                end
                `CEI_ADDR_RAW:
                begin
                    rdata_d = raw_level;
                end
                `CEI_ADDR_GPIO_MASK:
                begin
                    rdata_d = gpio_mask_q;
                end
                `CEI_ADDR_CORE_MASK:
                begin
                    rdata_d = core_mask_q;
                end
                `CEI_ADDR_CTRL:
                begin
                    rdata_d = ctrl_q;
                end
                default:
                begin
                    rdata_d = '0;
                end
            endcase
        end
    end

    // read data stands only in the cycle after the strobe
    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            rdata_q <= '0;
        end
        else if (clk_en)
        begin
            rdata_q <= rdata_d;
        end
    end

    // held until cleared
    // uses next latch state so irq drops in the same edge the last clear lands
    always_comb
    begin
        irq_d = !ctrl_q[`CEI_BIT_GLOBAL_MASK]
            && (|(gpio_evt_d & ~gpio_mask_q) || |(core_evt_d & ~core_mask_q));
    end

    // registered so the host sees a glitch-free level
    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            irq_q <= 1'b0;
        end
        else if (clk_en)
        begin
            irq_q <= irq_d;
        end
    end

    assign rdata = rdata_q;
    assign irq = irq_q;

endmodule

//--- src/cei_pkg_note_unused.sv
// reserved for shared items of the event interrupt unit; holds no code

//--- bench/cei_top_monitor.sv
// port checker of the event interrupt unit
// assumes one clock domain; bound to cei_top below
`timescale 1ns/1ps
`include "cei_consts.svh"
module cei_top_monitor
    import cei_pkg::*;
(
    // clock, reset, enable
    input wire logic mclk,
    input wire logic reset,
    input wire logic clk_en,
    // register port
    input wire cei_bus_s bus,
    input wire cei_word_t rdata,
    // sources and interrupt
    input wire logic [3:0] gpio_pin,
    input wire cei_src_s src,
    input wire logic irq
);
    logic gm_q;
    cei_word_t cm_q;
    logic [3:0] pm_q;
    cei_word_t raw_lv;
    default clocking @(posedge mclk); endclocking
    default disable iff (reset);
    assign raw_lv = {3'h0, src[9:6], 1'b0, src[5:4], 2'h0, 1'b0, src[2], 2'h0};
    // mask mirror, so irq can be tied to its enabling state
    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            gm_q <= 1'b1;
            cm_q <= 16'h1ecf;
            pm_q <= 4'hf;
        end
        else if (clk_en && bus.wr)
        begin
            if (bus.addr == `CEI_ADDR_CTRL)
                gm_q <= bus.wdata[0];
            if (bus.addr == `CEI_ADDR_CORE_MASK)
                cm_q <= bus.wdata & 16'h1ecf;
            if (bus.addr == `CEI_ADDR_GPIO_MASK)
                pm_q <= bus.wdata[3:0];
        end
    end
    chk_ctrl_readback: assert property (
        (clk_en && bus.rd && bus.addr == `CEI_ADDR_CTRL) |=> rdata == {15'h0, gm_q})
        else $error("control readback wrong");
    chk_raw_live: assert property (
        (clk_en && bus.rd && bus.addr == `CEI_ADDR_RAW) |=> rdata == $past(raw_lv))
        else $error("raw levels wrong");
    chk_global_mask: assert property ((gm_q && clk_en) |=> !irq)
        else $error("irq despite global mask");
    chk_lock_edge: assert property (
        (clk_en && $past(clk_en) && !$past(reset) && $changed(src.loop_lock_level)
        && !cm_q[2] && !gm_q)
        |=> irq)
        else $error("lock edge gave no irq");
    chk_servo_rise: assert property (
        (clk_en && $past(clk_en) && !$past(reset) && $rose(src.servo_pair_b_level)
        && !cm_q[12] && !gm_q)
        |=> irq)
        else $error("servo rise gave no irq");
    chk_masked_quiet: assert property (
        (clk_en && !irq && cm_q == 16'h1ecf && pm_q == 4'hf) |=> !irq)
        else $error("masked source raised irq");
    chk_irq_holds: assert property (
        (irq && clk_en && !bus.wr && !$past(bus.wr)) |=> irq)
        else $error("irq dropped without a write");
    chk_gpio_edge: assert property (
        (!$past(reset) && $changed(gpio_pin[0]) && !pm_q[0] && !gm_q
        ##0 clk_en [*3]) |=> irq)
        else $error("pin edge gave no irq");
endmodule

bind cei_top cei_top_monitor i_cei_top_monitor (.mclk, .reset, .clk_en, .bus, .rdata,
    .gpio_pin, .src, .irq);

//--- bench/cei_host_model.sv
// host model: register master and interrupt service routine
// assumes its tasks are called from one process at a time
`timescale 1ns/1ps
`include "cei_consts.svh"
module cei_host_model
    import cei_pkg::*;
(
    // clock
    input wire logic mclk,
    // register port
    output cei_bus_s bus,
    input wire cei_word_t rdata,
    // interrupt
    input wire logic irq
);
    initial
    begin
        bus = '0;
    end
    task automatic wr(input cei_word_t a, input cei_word_t d);
        @(posedge mclk);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge mclk);
        bus.wr <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic rd(input cei_word_t a, output cei_word_t d);
        @(posedge mclk);
        bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
        @(posedge mclk);
        bus.rd <= 1'b0;
        #1;
        d = rdata;
    endtask
    // a slow host lingers before it looks
    task automatic service(input int lag);
        cei_word_t v;
        repeat (lag) @(posedge mclk);
        rd(`CEI_ADDR_CORE_EVT, v);
        wr(`CEI_ADDR_CORE_EVT, v);
        rd(`CEI_ADDR_GPIO_EVT, v);
        wr(`CEI_ADDR_GPIO_EVT, v);
    endtask
endmodule

//--- bench/cei_top_tb_top.sv
// self-checking bench of the event interrupt unit
// assumes the host model owns the register port
`timescale 1ns/1ps
`include "cei_consts.svh"
module cei_top_tb_top
    import cei_pkg::*;
;
    logic mclk = 1'b0;
    logic reset = 1'b1;
    logic clk_en = 1'b1;
    logic [3:0] gpio_pin = 4'h0;
    cei_src_s src = '0;
    cei_bus_s bus;
    cei_word_t rdata;
    cei_word_t v;
    cei_word_t ev_q;
    logic irq;
    logic [9:0] r;
    logic [9:0] old;
    int fails = 0;
    int compares = 0;
    int seed = 64935;
    always #5 mclk = ~mclk;
    cei_top i_cei_top (.mclk, .reset, .clk_en, .bus, .rdata, .gpio_pin, .src, .irq);
    cei_host_model i_cei_host_model (.mclk, .bus, .rdata, .irq);
    function automatic cei_word_t lv(logic [9:0] s);
        return {3'h0, s[9:6], 1'b0, s[5:4], 2'h0, s[3:0]};
    endfunction
    // lock counts both edges, every other source rising only
    function automatic cei_word_t evt(logic [9:0] o, logic [9:0] n);
        return (lv(n) & ~lv(o)) | ((lv(n) ^ lv(o)) & 16'h0004);
    endfunction
    task automatic chk(input cei_word_t got, input cei_word_t exp);
        compares++;
        if (got !== exp)
            $display("BAD %0t got %h expected %h", $time, got, exp);
        if (got !== exp)
            fails++;
    endtask
    task automatic wr(input cei_word_t a, input cei_word_t d);
        i_cei_host_model.wr(a, d);
    endtask
    task automatic rc(input cei_word_t a, input cei_word_t exp);
        i_cei_host_model.rd(a, v);
        chk(v, exp);
    endtask
    task automatic ci(input logic e);
        #1;
        chk(16'(irq), 16'(e));
    endtask
    task automatic results();
        if (fails == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial
    begin
        repeat (20000) @(posedge mclk);
        fails++;
        results();
    end
    initial
    begin
        repeat (3) @(posedge mclk);
        reset <= 1'b0;
        rc(`CEI_ADDR_CTRL, 16'h0001);
        rc(`CEI_ADDR_CORE_MASK, 16'h1ecf);
        rc(`CEI_ADDR_GPIO_MASK, 16'h000f);
        rc(16'h0733, 16'h0000);
        wr(`CEI_ADDR_CORE_MASK, 16'hffff);
        rc(`CEI_ADDR_CORE_MASK, 16'h1ecf);
        wr(`CEI_ADDR_GPIO_MASK, 16'hffff);
        rc(`CEI_ADDR_GPIO_MASK, 16'h000f);
        wr(`CEI_ADDR_RAW, 16'hffff);
        rc(`CEI_ADDR_RAW, 16'h0000);
        // random activity while every source is masked
        ev_q = 16'h0000;
        old = 10'h000;
        repeat (40)
        begin
            r = 10'($random(seed));
            @(posedge mclk);
            src <= cei_src_s'(r);
            ev_q = ev_q | evt(old, r);
            old = r;
            repeat (2) @(posedge mclk);
            rc(`CEI_ADDR_RAW, lv(r) & 16'h1ec4);
            rc(`CEI_ADDR_CORE_EVT, ev_q);
            ci(1'b0);
            v = 16'($random(seed));
            wr(`CEI_ADDR_CORE_EVT, v);
            ev_q = ev_q & ~v;
        end
        @(posedge mclk);
        src <= '0;
        repeat (2) @(posedge mclk);
        wr(`CEI_ADDR_CORE_EVT, 16'hffff);
        wr(`CEI_ADDR_CORE_MASK, 16'h0000);
        wr(`CEI_ADDR_CTRL, 16'h0000);
        ci(1'b0);
        // each source alone, rising then falling, fast and slow host
        for (int i = 0; i < 10; i++)
        begin
            @(posedge mclk);
            src <= cei_src_s'(10'h1 << i);
            repeat (2) @(posedge mclk);
            ci(1'b1);
            rc(`CEI_ADDR_CORE_EVT, lv(10'h1 << i));
            i_cei_host_model.service(i % 3);
            ci(1'b0);
            @(posedge mclk);
            src <= '0;
            repeat (2) @(posedge mclk);
            ci(i == 2);
            i_cei_host_model.service(0);
        end
        @(posedge mclk);
        src <= cei_src_s'(10'h001);
        repeat (2) @(posedge mclk);
        wr(`CEI_ADDR_CTRL, 16'h0001);
        repeat (2) @(posedge mclk);
        ci(1'b0);
        wr(`CEI_ADDR_CTRL, 16'h0000);
        repeat (2) @(posedge mclk);
        ci(1'b1);
        wr(`CEI_ADDR_CORE_MASK, 16'h0001);
        repeat (2) @(posedge mclk);
        ci(1'b0);
        rc(`CEI_ADDR_CORE_EVT, 16'h0001);
        wr(`CEI_ADDR_CORE_EVT, 16'h0001);
        wr(`CEI_ADDR_GPIO_MASK, 16'h0000);
        // each pin rising, then each falling
        for (int p = 0; p < 8; p++)
        begin
            @(posedge mclk);
            gpio_pin <= gpio_pin ^ (4'h1 << (p % 4));
            repeat (5) @(posedge mclk);
            ci(1'b1);
            rc(`CEI_ADDR_GPIO_EVT, 16'h0001 << (p % 4));
            wr(`CEI_ADDR_GPIO_EVT, 16'h000f);
            ci(1'b0);
        end
        // a frozen clock enable drops strobes and delays edges until it returns
        @(posedge mclk);
        clk_en <= 1'b0;
        src <= cei_src_s'(10'h003);
        wr(`CEI_ADDR_CTRL, 16'h0001);
        ci(1'b0);
        @(posedge mclk);
        clk_en <= 1'b1;
        repeat (2) @(posedge mclk);
        ci(1'b1);
        rc(`CEI_ADDR_CTRL, 16'h0000);
        rc(`CEI_ADDR_CORE_EVT, 16'h0002);
        wr(`CEI_ADDR_CORE_EVT, 16'h0002);
        ci(1'b0);
        // pins and sources held high through a reset must not read as edges
        @(posedge mclk);
        gpio_pin <= 4'hf;
        reset <= 1'b1;
        repeat (3) @(posedge mclk);
        reset <= 1'b0;
        rc(`CEI_ADDR_CTRL, 16'h0001);
        rc(`CEI_ADDR_CORE_MASK, 16'h1ecf);
        wr(`CEI_ADDR_GPIO_MASK, 16'h0000);
        wr(`CEI_ADDR_CTRL, 16'h0000);
        repeat (4) @(posedge mclk);
        rc(`CEI_ADDR_GPIO_EVT, 16'h0000);
        rc(`CEI_ADDR_CORE_EVT, 16'h0000);
        ci(1'b0);
        results();
    end
endmodule
